// *** rtl/uwob_pkg.sv ***
package uwob_pkg;
  // register offsets of the serial port
  localparam logic [7:0] UWOB_OFS_RX_STATUS = 8'h18;
  localparam logic [7:0] UWOB_OFS_TX_BUF = 8'h19;
  localparam logic [7:0] UWOB_OFS_RX_BUF = 8'h1A;
  // offsets of the added control registers
  localparam logic [7:0] UWOB_OFS_BAUD_CTL = 8'h1B;
  localparam logic [7:0] UWOB_OFS_INT_STAT = 8'h1C;
  localparam logic [7:0] UWOB_OFS_INT_MASK = 8'h1D;
  // bit positions
  localparam int UWOB_BIT_WAKE_EN = 1;
  localparam int UWOB_BIT_SYNC = 4;
  localparam int UWOB_BIT_SLEEP = 5;
  localparam int UWOB_BIT_RX_IDLE = 6;
  localparam int UWOB_BIT_FERR = 2;
  localparam int UWOB_BIT_OERR = 1;
  localparam int UWOB_BIT_RX_INT = 0;
  localparam int UWOB_BIT_WAKE_DONE = 1;
  // reset values
  localparam logic [7:0] UWOB_RST_BYTE = 8'h00;
  localparam logic [7:0] UWOB_RST_BAUD_DIV = 8'h07;
  // bit time in system clocks (10 MHz clock)
  localparam int UWOB_BIT_TIME_NS = 10000;
  localparam int UWOB_CLK_NS = 100;
  localparam int UWOB_BIT_CYC = UWOB_BIT_TIME_NS / UWOB_CLK_NS;
  localparam int UWOB_BREAK_BITS = 13;
  localparam int UWOB_IDLE_BITS = 2;
  localparam int UWOB_DATA_BITS = 8;
  localparam logic [15:0] UWOB_BIT_CNT = 16'(UWOB_BIT_CYC);
  localparam logic [15:0] UWOB_HALF_CNT = 16'(UWOB_BIT_CYC / 2);
endpackage

// *** rtl/uwob_link_if.sv ***
`timescale 1ns/1ns
interface uwob_link_if;
  logic receive_data_line; // idle high serial line
  modport dev (input receive_data_line);
  modport far (output receive_data_line);
endinterface

// *** rtl/uwob_remote_tx.sv ***
`timescale 1ns/1ns
module uwob_remote_tx
  import uwob_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // link
  uwob_link_if.far link,
  // user side
  input wire logic i_send_break,
  input wire logic i_send_byte,
  input wire logic [7:0] i_byte,
  output logic o_busy
);
  typedef enum logic [1:0] {UWOBT_IDLE, UWOBT_SHIFT, UWOBT_GAP} uwobt_state_t;
  uwobt_state_t state_q;
  logic [15:0] cnt_q;
  logic [4:0] bits_q;
  logic [15:0] shreg_q;
  logic line_q;

  // frame sequencer: break is all-zero frame of 13 bits plus idle gap
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      state_q <= UWOBT_IDLE;
      cnt_q <= 16'h0000;
      bits_q <= 5'h00;
      shreg_q <= 16'hFFFF;
      line_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        UWOBT_IDLE:
        begin
          line_q <= 1'b1;
          if (i_send_break)
          begin
            shreg_q <= 16'h0000;
            bits_q <= 5'(UWOB_BREAK_BITS);
            cnt_q <= UWOB_BIT_CNT;
            line_q <= 1'b0;
            state_q <= UWOBT_SHIFT;
          end
          else if (i_send_byte)
          begin
            shreg_q <= {6'h3F, 1'b1, i_byte, 1'b0};
            bits_q <= 5'(UWOB_DATA_BITS + 2);
            cnt_q <= UWOB_BIT_CNT;
            line_q <= 1'b0;
            state_q <= UWOBT_SHIFT;
          end
        end
        UWOBT_SHIFT:
        begin
          if (cnt_q == 16'h0001)
          begin
            cnt_q <= UWOB_BIT_CNT;
            shreg_q <= {1'b1, shreg_q[15:1]};
            bits_q <= bits_q - 5'h01;
            line_q <= shreg_q[1];
            if (bits_q == 5'h01)
            begin
              line_q <= 1'b1;
              bits_q <= 5'(UWOB_IDLE_BITS);
              state_q <= UWOBT_GAP;
            end
          end
          else
            cnt_q <= cnt_q - 16'h0001;
        end
        UWOBT_GAP:
        begin
          line_q <= 1'b1;
          if (cnt_q == 16'h0001)
          begin
            cnt_q <= UWOB_BIT_CNT;
            bits_q <= bits_q - 5'h01;
            if (bits_q == 5'h01)
              state_q <= UWOBT_IDLE;
          end
          else
            cnt_q <= cnt_q - 16'h0001;
        end
        default: state_q <= UWOBT_IDLE;
      endcase
    end
  end

  assign link.receive_data_line = line_q;
  assign o_busy = (state_q != UWOBT_IDLE);
endmodule

// *** rtl/uwob_device.sv ***
`timescale 1ns/1ns
module uwob_device
  import uwob_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // link
  uwob_link_if.dev link,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // status
  output logic o_irq,
  output logic o_wake
);
  typedef enum logic [1:0] {UWOB_RX_IDLE, UWOB_RX_START, UWOB_RX_DATA, UWOB_RX_STOP} uwob_rx_state_t;
  uwob_rx_state_t rx_state_q;
  logic [2:0] sync_q;
  logic line_q;
  logic [7:0] baud_q;
  logic [7:0] rx_buf_q;
  logic [7:0] shift_q;
  logic [15:0] cnt_q;
  logic [3:0] nbit_q;
  logic rx_full_q;
  logic wake_int_q;
  logic brk_low_q;
  logic ferr_q;
  logic oerr_q;
  logic [1:0] int_stat_q;
  logic [1:0] int_mask_q;
  logic [7:0] rdata_q;
  logic fall;
  logic rise;
  logic wake_armed;
  logic sleeping;
  logic rx_done;
  logic rd_buf;
  logic [1:0] int_ev;

  // register address decode, used for the writes and the buffer read
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // three-stage line sampler, change counted when last two agree
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      sync_q <= 3'h7;
      line_q <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], link.receive_data_line};
      if (sync_q[2] == sync_q[1])
        line_q <= sync_q[1];
    end
  end

  // edges of the filtered line, any low of two or more clocks accepted
  assign fall = line_q & ~sync_q[2] & ~sync_q[1];
  assign rise = ~line_q & sync_q[2] & sync_q[1];
  assign sleeping = baud_q[UWOB_BIT_SLEEP];
  assign wake_armed = baud_q[UWOB_BIT_WAKE_EN] & ~baud_q[UWOB_BIT_SYNC];
  assign rd_buf = i_rd & hit(i_addr, UWOB_OFS_RX_BUF);

  // baud control: wake enable, sync mode, sleep; hardware clears wake enable unless sync mode is set
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      baud_q <= UWOB_RST_BYTE;
    else
    begin
      if (i_wr && hit(i_addr, UWOB_OFS_BAUD_CTL))
        baud_q <= i_wdata;
      if (wake_armed && brk_low_q && rise)
        baud_q[UWOB_BIT_WAKE_EN] <= 1'b0;
    end
  end

  // low period seen while armed, kept apart from the interrupt flag
  // so that an early buffer read cannot leave the enable set
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || !wake_armed)
      brk_low_q <= 1'b0;
    else if (fall)
      brk_low_q <= 1'b1;
    else if (rise)
      brk_low_q <= 1'b0;
  end

  // wake interrupt condition, the set wins over the buffer read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      wake_int_q <= 1'b0;
    else if (wake_armed && fall)
      wake_int_q <= 1'b1;
    else if (rd_buf)
      wake_int_q <= 1'b0;
  end

  // normal receiver, frozen while armed or asleep
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || wake_armed || sleeping)
    begin
      rx_state_q <= UWOB_RX_IDLE;
      cnt_q <= 16'h0000;
      nbit_q <= 4'h0;
      shift_q <= UWOB_RST_BYTE;
    end
    else
    begin
      case (rx_state_q)
        UWOB_RX_IDLE:
          if (fall && !baud_q[UWOB_BIT_SYNC])
          begin
            cnt_q <= UWOB_HALF_CNT;
            rx_state_q <= UWOB_RX_START;
          end
        UWOB_RX_START:
          if (cnt_q == 16'h0001)
          begin
            cnt_q <= UWOB_BIT_CNT;
            nbit_q <= 4'h0;
            rx_state_q <= line_q ? UWOB_RX_IDLE : UWOB_RX_DATA;
          end
          else
            cnt_q <= cnt_q - 16'h0001;
        UWOB_RX_DATA:
          if (cnt_q == 16'h0001)
          begin
            cnt_q <= UWOB_BIT_CNT;
            shift_q <= {line_q, shift_q[7:1]};
            nbit_q <= nbit_q + 4'h1;
            if (nbit_q == 4'(UWOB_DATA_BITS - 1))
              rx_state_q <= UWOB_RX_STOP;
          end
          else
            cnt_q <= cnt_q - 16'h0001;
        UWOB_RX_STOP:
          if (cnt_q == 16'h0001)
            rx_state_q <= UWOB_RX_IDLE;
          else
            cnt_q <= cnt_q - 16'h0001;
        default: rx_state_q <= UWOB_RX_IDLE;
      endcase
    end
  end

  assign rx_done = (rx_state_q == UWOB_RX_STOP) && (cnt_q == 16'h0001);

  // receive buffer, framing and overrun flags
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      rx_buf_q <= UWOB_RST_BYTE;
      rx_full_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_buf_q <= shift_q;
      rx_full_q <= 1'b1;
      ferr_q <= ~line_q;
      oerr_q <= oerr_q | (rx_full_q & ~rd_buf);
    end
    else if (rd_buf)
    begin
      rx_full_q <= 1'b0;
      oerr_q <= 1'b0;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign int_ev = {wake_armed & brk_low_q & rise, (wake_armed & fall) | rx_done};
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      int_stat_q <= 2'h0;
      int_mask_q <= 2'h0;
    end
    else
    begin
      if (i_wr && hit(i_addr, UWOB_OFS_INT_MASK))
        int_mask_q <= i_wdata[1:0];
      if (i_wr && hit(i_addr, UWOB_OFS_INT_STAT))
        int_stat_q <= (int_stat_q & ~i_wdata[1:0]) | int_ev;
      else
        int_stat_q <= int_stat_q | int_ev;
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || !i_rd)
      rdata_q <= UWOB_RST_BYTE;
    else
    begin
      case (i_addr)
        UWOB_OFS_RX_STATUS: rdata_q <= {1'b0, (rx_state_q == UWOB_RX_IDLE), 3'h0, ferr_q, oerr_q,
                                        rx_full_q | wake_int_q};
        UWOB_OFS_RX_BUF: rdata_q <= rx_buf_q;
        UWOB_OFS_BAUD_CTL: rdata_q <= baud_q;
        UWOB_OFS_INT_STAT: rdata_q <= {6'h00, int_stat_q};
        UWOB_OFS_INT_MASK: rdata_q <= {6'h00, int_mask_q};
        default: rdata_q <= UWOB_RST_BYTE;
      endcase
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = |(int_stat_q & int_mask_q);
  // wake request to the core while asleep
  assign o_wake = sleeping & wake_int_q;
endmodule

// *** bench/uwob_link_sva.sv ***
`timescale 1ns/1ns
module uwob_link_sva (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // watched line
  input wire logic receive_data_line
);
  logic [15:0] low_q;
  logic [15:0] high_q;
  logic brk_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // length of the current low run
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || receive_data_line)
      low_q <= 16'h0000;
    else
      low_q <= low_q + 16'h0001;
  end
  // length of the current high run
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || !receive_data_line)
      high_q <= 16'h0000;
    else
      high_q <= high_q + 16'h0001;
  end
  // a full break has just ended
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || !receive_data_line)
      brk_q <= 1'b0;
    else if (low_q == 16'h0514)
      brk_q <= 1'b1;
  end
  chk_idle_after_reset: assert property ($fell(i_srst) |-> receive_data_line)
    else $error("line not idle after reset");
  chk_break_max: assert property (low_q <= 16'h0514)
    else $error("low run longer than a break");
  chk_low_whole_bits: assert property ($rose(receive_data_line) |-> low_q % 16'h0064 == 16'h0000)
    else $error("low run not whole bit times");
  chk_long_low_break: assert property ($rose(receive_data_line) && low_q > 16'h0384 |-> low_q == 16'h0514)
    else $error("long low run is not a full break");
  chk_break_gap: assert property ($fell(receive_data_line) && brk_q |-> high_q >= 16'h00C8)
    else $error("idle gap after break too short");
  chk_low_min_bit: assert property ($rose(receive_data_line) |-> low_q >= 16'h0064)
    else $error("low run shorter than a bit");
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import uwob_pkg::*;
  localparam logic [7:0] WK = 8'h01 << UWOB_BIT_WAKE_EN;
  localparam logic [7:0] SY = 8'h01 << UWOB_BIT_SYNC;
  localparam logic [7:0] SL = 8'h01 << UWOB_BIT_SLEEP;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_send_break = 1'b0;
  logic i_send_byte = 1'b0;
  logic [7:0] i_byte = 8'h00;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_wake;
  logic o_busy;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 22940;
  logic [7:0] q[$];
  uwob_link_if link();
  // system clock, 100 ns
  always #50 i_sys_clk = ~i_sys_clk;
  // both ends of the link
  uwob_remote_tx uwob_remote_tx_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .link(link.far),
    .i_send_break(i_send_break), .i_send_byte(i_send_byte), .i_byte(i_byte), .o_busy(o_busy));
  uwob_device uwob_device_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .link(link.dev), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake));
  uwob_link_sva uwob_link_sva_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .receive_data_line(link.receive_data_line));
  // comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input string what);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata & m, exp, what);
  endtask
  // remote requests and bounded wait for its end
  task automatic send(input logic brk, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_send_break <= brk;
    i_send_byte <= !brk;
    i_byte <= d;
    @(posedge i_sys_clk);
    i_send_break <= 1'b0;
    i_send_byte <= 1'b0;
  endtask
  task automatic idle();
    int i;
    #1;
    for (i = 0; i < 3000 && o_busy !== 1'b0; i++)
      @(posedge i_sys_clk);
    if (i == 3000)
    begin
      n_fail++;
      print_verdict();
    end
  endtask
  // main sequence
  initial
  begin
    int k;
    int ev;
    logic [7:0] ctl;
    repeat (16) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    wr(8'h3F, 8'hFF);
    rd(UWOB_OFS_RX_BUF, 8'hFF, 8'h00, "rx buf reset");
    rd(UWOB_OFS_TX_BUF, 8'hFF, 8'h00, "tx buf read");
    rd(UWOB_OFS_INT_STAT, 8'hFF, 8'h00, "status reset");
    rd(UWOB_OFS_RX_STATUS, 8'h41, 8'h40, "idle at reset");
    wr(UWOB_OFS_INT_MASK, 8'h03);
    // wake: async break, sync break, sleep break, async data
    for (k = 0; k < 4; k++)
    begin
      ctl = (k == 1) ? (WK | SY) : (k == 2) ? (WK | SL) : WK;
      ev = (k != 1);
      rd(UWOB_OFS_RX_STATUS, 8'h40, 8'h40, "idle before arm");
      wr(UWOB_OFS_BAUD_CTL, ctl);
      rd(UWOB_OFS_BAUD_CTL, 8'hFF, ctl, "armed");
      send(k != 3, 8'($random(seed)) | 8'h01);
      repeat (10) @(posedge i_sys_clk);
      rd(UWOB_OFS_INT_STAT, 8'h01, 8'(ev), "wake event");
      check(8'(o_irq), 8'(ev), "irq");
      check(8'(o_wake), 8'(k == 2), "wake out");
      if (k == 0)
      begin
        rd(UWOB_OFS_RX_STATUS, 8'h41, 8'h41, "held idle");
        wr(UWOB_OFS_INT_MASK, 8'h00);
        #1 check(8'(o_irq), 8'h00, "irq masked");
        wr(UWOB_OFS_INT_MASK, 8'h03);
        // buffer read during the break must not keep the enable set
        rd(UWOB_OFS_RX_BUF, 8'hFF, 8'h00, "early discard");
      end
      idle();
      // let the fragment after a data wake finish
      if (k == 3)
        repeat (UWOB_BIT_CYC * 10) @(posedge i_sys_clk);
      rd(UWOB_OFS_BAUD_CTL, 8'hFF, (k == 1) ? ctl : (ctl & ~WK), "wake cleared");
      rd(UWOB_OFS_INT_STAT, 8'h02, 8'(ev << 1), "wake done");
      rd(UWOB_OFS_RX_BUF, (k == 3) ? 8'h00 : 8'hFF, 8'h00, "discard");
      rd(UWOB_OFS_RX_STATUS, 8'h01, 8'h00, "int cleared");
      check(8'(o_wake), 8'h00, "wake out off");
      wr(UWOB_OFS_INT_STAT, 8'h03);
      rd(UWOB_OFS_INT_STAT, 8'hFF, 8'h00, "status w1c");
      check(8'(o_irq), 8'h00, "irq off");
    end
    // normal reception, then sleep blocks reception
    wr(UWOB_OFS_BAUD_CTL, 8'h00);
    q.push_back(8'($random(seed)));
    send(1'b0, q[0]);
    repeat (300) @(posedge i_sys_clk);
    rd(UWOB_OFS_RX_STATUS, 8'h40, 8'h00, "busy flag");
    idle();
    rd(UWOB_OFS_RX_STATUS, 8'h41, 8'h41, "byte done");
    rd(UWOB_OFS_RX_BUF, 8'hFF, q.pop_front(), "rx byte");
    wr(UWOB_OFS_BAUD_CTL, SL);
    send(1'b0, 8'h55);
    idle();
    rd(UWOB_OFS_RX_STATUS, 8'h01, 8'h00, "asleep");
    print_verdict();
  end
endmodule
